// ### hw/system_clock_source_divider_select.sv
// system clock source and divider selection with instruction clock generation
// assumes oscillator pins are asynchronous and far slower than clk; rates leave as enables
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "clk_defs.svh"

module system_clock_source_divider_select #(
  parameter int RING_DIV = `RING_DIV_DEFAULT
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   main_osc_in,
  input  wire logic                   sub_osc_in,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`DATA_W-1:0]     wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`DATA_W-1:0]     rdata,
  output logic                        sys_clk,
  output logic                        instruction_clk,
  output logic                        machine_cycle,
  output clk_pkg::clk_src_t           active_src
);
  import clk_pkg::*;

  // the ring stand-in needs a whole count; the read mux hands out fixed counter nibbles
  if (RING_DIV < 1) begin : g_ring_div_check
    $error("RING_DIV must be at least 1");
  end
  if (`MCYC_W != 16) begin : g_mcyc_check
    $error("machine cycle counter must be 16 bits for the nibble map");
  end
  if (`MODE_DIV_LSB + 2 > `DATA_W) begin : g_field_check
    $error("mode fields do not fit the data width");
  end

  localparam int RW = $clog2(RING_DIV + 1);

  // reset mode split into its fields once, so both registers agree with the header
  localparam clk_src_t  RESET_SRC = clk_src_t'(`MODE_RESET >> `MODE_SRC_LSB);
  localparam div_code_t RESET_DIV = div_code_t'(`MODE_RESET >> `MODE_DIV_LSB);

  // one register index compare, shared by every strobe decode
  function automatic logic hit(input logic               strobe,
                               input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] idx);
    hit = strobe && (a == idx);
  endfunction

  // nibble k of a counter value, as the read port hands it out
  function automatic logic [`DATA_W-1:0] nib(input logic [`MCYC_W-1:0] v,
                                             input int                 k);
    nib = v[k*`DATA_W +: `DATA_W];
  endfunction

  logic main_rise, sub_rise;

  edge_sync u_main (
    .clk  (clk),
    .rst  (rst),
    .pin  (main_osc_in),
    .rise (main_rise)
  );

  edge_sync u_sub (
    .clk  (clk),
    .rst  (rst),
    .pin  (sub_osc_in),
    .rise (sub_rise)
  );

  // on-chip oscillator stand-in: a free divider of clk
  logic [RW-1:0] ring_cnt_q, ring_cnt_d;
  logic          ring_tick_q, ring_tick_d;

  always_comb begin
    ring_tick_d = 1'b0;
    if (ring_cnt_q >= RW'(RING_DIV - 1)) begin
      ring_cnt_d  = '0;
      ring_tick_d = 1'b1;
    end else begin
      ring_cnt_d  = RW'(ring_cnt_q + RW'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_cnt_q  <= '0;
      ring_tick_q <= 1'b0;
    end else begin
      ring_cnt_q  <= ring_cnt_d;
      ring_tick_q <= ring_tick_d;
    end
  end

  // mode register: source held apart so an unsupported code cannot disturb it
  clk_src_t  src_q, src_d;
  div_code_t divc_q, divc_d;
  logic      restart_q, restart_d;
  logic      wr_mode, wr_mcyc, rd_mcyc, rd_status;

  // every register strobe decoded in one place
  always_comb begin
    wr_mode   = hit(wr, addr, `ADDR_MODE);
    wr_mcyc   = hit(wr, addr, `ADDR_MCYC0);
    rd_mcyc   = hit(rd, addr, `ADDR_MCYC0);
    rd_status = hit(rd, addr, `ADDR_STATUS);
  end

  always_comb begin
    src_d     = src_q;
    divc_d    = divc_q;
    restart_d = 1'b0;
    if (wr_mode) begin
      divc_d    = wdata[`MODE_DIV_LSB +: 2]; // see RULE_04
      restart_d = 1'b1;
      if (wdata[`MODE_SRC_LSB +: 2] != `SRC_NONE) begin // see RULE_08
        src_d = wdata[`MODE_SRC_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_q     <= RESET_SRC; // see RULE_05
      divc_q    <= RESET_DIV; // see RULE_05
      restart_q <= 1'b0;
    end else begin
      src_q     <= src_d;
      divc_q    <= divc_d;
      restart_q <= restart_d;
    end
  end

  // source tick mux
  logic src_tick;

  always_comb begin
    case (src_q)
      `SRC_RING: src_tick = ring_tick_q; // see RULE_01
      `SRC_MAIN: src_tick = main_rise;   // see RULE_02
      `SRC_SUB:  src_tick = sub_rise;    // see RULE_03
      default:   src_tick = 1'b0;
    endcase
  end

  div_if #(.W(`RATIO_W)) sys_bus ();
  div_if #(.W(`RATIO_W)) ins_bus ();

  // restart both dividers on a mode write so the first period after a switch is whole
  assign sys_bus.in_tick = src_tick;
  assign sys_bus.ratio   = div_ratio(divc_q); // see RULE_04
  assign sys_bus.clear   = restart_q;

  pulse_div #(.W(`RATIO_W)) u_sys_div (
    .clk (clk),
    .rst (rst),
    .d   (sys_bus.div)
  );

  assign ins_bus.in_tick = sys_bus.out_tick;
  assign ins_bus.ratio   = `INST_DIV; // see RULE_06
  assign ins_bus.clear   = restart_q;

  pulse_div #(.W(`RATIO_W)) u_ins_div (
    .clk (clk),
    .rst (rst),
    .d   (ins_bus.div)
  );

  assign sys_clk         = sys_bus.out_tick;
  assign instruction_clk = ins_bus.out_tick;
  assign machine_cycle   = ins_bus.out_tick; // see RULE_07
  assign active_src      = src_q;

  // machine cycle counter with a snapshot taken when the low nibble is read
  logic [`MCYC_W-1:0] mcyc_q, mcyc_d;
  logic [`MCYC_W-1:0] snap_q, snap_d;

  always_comb begin
    mcyc_d = mcyc_q;
    snap_d = snap_q;
    if (wr_mcyc) begin
      mcyc_d = {{(`MCYC_W-1){1'b0}}, ins_bus.out_tick};
    end else if (ins_bus.out_tick) begin
      mcyc_d = `MCYC_W'(mcyc_q + `MCYC_W'(1)); // see RULE_07
    end
    if (rd_mcyc) begin
      snap_d = mcyc_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mcyc_q <= '0;
      snap_q <= '0;
    end else begin
      mcyc_q <= mcyc_d;
      snap_q <= snap_d;
    end
  end

  // oscillator activity flags, cleared by reading status; a new edge wins over the clear
  logic main_seen_q, main_seen_d;
  logic sub_seen_q, sub_seen_d;

  always_comb begin
    main_seen_d = main_rise | (main_seen_q & ~rd_status);
    sub_seen_d  = sub_rise  | (sub_seen_q  & ~rd_status);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      main_seen_q <= 1'b0;
      sub_seen_q  <= 1'b0;
    end else begin
      main_seen_q <= main_seen_d;
      sub_seen_q  <= sub_seen_d;
    end
  end

  // read port, data in the cycle after the strobe
  logic [`DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = '0;
    if (rd) begin
      case (addr)
        `ADDR_MODE:   rdata_d = {divc_q, src_q};
        `ADDR_STATUS: rdata_d = {ins_bus.phase[1:0], sub_seen_q, main_seen_q};
        `ADDR_MCYC0:  rdata_d = nib(mcyc_q, 0);
        `ADDR_MCYC1:  rdata_d = nib(snap_q, 1);
        `ADDR_MCYC2:  rdata_d = nib(snap_q, 2);
        `ADDR_MCYC3:  rdata_d = nib(snap_q, 3);
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule

// ### hw/clk_defs.svh
// offsets, field positions, reset values and counts of the system clock selector
// assumes inclusion by bare name from the package and the modules
// How it works
// RULE_01 - source code 00 in the mode register selects the on-chip oscillator
// RULE_02 - source code 01 selects the main oscillator input
// RULE_03 - source code 10 selects the sub-oscillator input
// RULE_04 - divide code 11 gives /8, 10 gives /4, 01 gives /2, 00 passes through
// RULE_05 - after reset the on-chip oscillator divided by eight is selected
// RULE_06 - instruction clock is the system clock divided by three
// RULE_07 - one instruction clock cycle is one machine cycle
// RULE_08 - source code 11 is ignored and keeps the active source
`ifndef CLK_DEFS_SVH
`define CLK_DEFS_SVH

`define ADDR_W            3
`define DATA_W            4
`define ADDR_MODE         3'h0
`define ADDR_STATUS       3'h1
`define ADDR_MCYC0        3'h2
`define ADDR_MCYC1        3'h3
`define ADDR_MCYC2        3'h4
`define ADDR_MCYC3        3'h5

`define MODE_SRC_LSB      0
`define MODE_DIV_LSB      2
`define MODE_RESET        4'hC

`define SRC_RING          2'h0
`define SRC_MAIN          2'h1
`define SRC_SUB           2'h2
`define SRC_NONE          2'h3

`define DIV_THRU          2'h0
`define DIV_2             2'h1
`define DIV_4             2'h2
`define DIV_8             2'h3

`define STAT_MAIN_BIT     0
`define STAT_SUB_BIT      1
`define STAT_PHASE_LSB    2

`define RATIO_W           4
`define INST_DIV          4'h3
`define RING_DIV_DEFAULT  8
`define MCYC_W            16

`endif

// ### hw/clk_pkg.sv
// types and helpers shared by the clock selector modules
// assumes clk_defs.svh is on the include path
`include "clk_defs.svh"

package clk_pkg;

  typedef logic [1:0]          clk_src_t;
  typedef logic [1:0]          div_code_t;
  typedef logic [`RATIO_W-1:0] ratio_t;

  // divide code to number of source ticks per system tick
  function automatic ratio_t div_ratio(input div_code_t code);
    case (code)
      `DIV_8:  div_ratio = 4'h8;
      `DIV_4:  div_ratio = 4'h4;
      `DIV_2:  div_ratio = 4'h2;
      default: div_ratio = 4'h1;
    endcase
  endfunction

endpackage

// ### hw/div_if.sv
// carrier between the selector and a tick divider
// assumes both ends run on the one system clock
`timescale 1ns/1ps

interface div_if #(
  parameter int W = 4
);
  logic         in_tick;
  logic [W-1:0] ratio;
  logic         clear;
  logic         out_tick;
  logic [W-1:0] phase;

  modport ctrl (output in_tick, output ratio, output clear, input out_tick, input phase);
  modport div  (input in_tick, input ratio, input clear, output out_tick, output phase);
endinterface

// ### hw/edge_sync.sv
// three-stage synchroniser with rising edge detect for an oscillator pin
// assumes the pin toggles well below half the clk rate
`timescale 1ns/1ps

module edge_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise
);

  logic s1_q, s2_q, s3_q, lvl_q, rise_q;
  logic lvl_d, rise_d;

  always_comb begin
    // level moves only once the two later stages agree
    lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
    rise_d = lvl_d & ~lvl_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign rise = rise_q;

endmodule

// ### hw/pulse_div.sv
// divides a tick stream by a run-time ratio, one output pulse per ratio input ticks
// assumes ratio is at least one and stable between clears
`timescale 1ns/1ps

module pulse_div #(
  parameter int W = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  div_if.div        d
);

  logic [W-1:0] cnt_q, cnt_d;
  logic         out_q, out_d;

  // a one-bit count cannot hold the divide ratios of the clock tree
  if (W < 2) begin : g_width_check
    $error("pulse_div needs W of at least 2");
  end

  always_comb begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (d.clear) begin
      cnt_d = '0;
    end else if (d.in_tick) begin
      if (cnt_q >= W'(d.ratio - W'(1))) begin
        cnt_d = '0;
        out_d = 1'b1;
      end else begin
        cnt_d = W'(cnt_q + W'(1));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign d.out_tick = out_q;
  assign d.phase    = cnt_q;

endmodule

// ### sim/sel_chk.sv
// port assertions for the system clock selector
// assumes it is bound into the top module with its RING_DIV
`timescale 1ns/1ps
`include "clk_defs.svh"
module sel_chk #(
  parameter int RING_DIV = 2
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               main_osc_in,
  input wire logic               sub_osc_in,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [`DATA_W-1:0] rdata,
  input wire logic               sys_clk,
  input wire logic               instruction_clk,
  input wire logic               machine_cycle,
  input wire clk_pkg::clk_src_t  active_src
);
  import clk_pkg::*;
  localparam int RT = 2 * RING_DIV + 3;
  wire mw = wr && addr == `ADDR_MODE;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RING: assert property (mw && wdata[1:0] == `SRC_RING |=> active_src == `SRC_RING)
    else $error("ring source not taken");
  AST_MAIN: assert property (mw && wdata[1:0] == `SRC_MAIN |=> active_src == `SRC_MAIN)
    else $error("main source not taken");
  AST_SUB: assert property (mw && wdata[1:0] == `SRC_SUB |=> active_src == `SRC_SUB)
    else $error("sub source not taken");
  // the cleared divider needs eight ring ticks, so no tick may come early
  AST_DIV8: assert property (mw && wdata == 4'hC |=> ##1 !sys_clk [*8])
    else $error("divide by eight too fast");
  AST_THRU: assert property (mw && wdata == 4'h0 |=> ##[1:RT] sys_clk)
    else $error("through mode too slow");
  AST_RESET: assert property ($fell(rst) |-> active_src == `SRC_RING && !sys_clk ##1 !sys_clk [*8])
    else $error("reset mode not ring divided by eight");
  AST_INST: assert property (instruction_clk |-> $past(sys_clk))
    else $error("instruction tick without system tick");
  AST_MCYC: assert property (machine_cycle == instruction_clk)
    else $error("machine cycle differs from instruction tick");
  AST_KEEP: assert property (mw && wdata[1:0] == `SRC_NONE |=> $stable(active_src))
    else $error("source changed on code three");
  COV_SUB: cover property (active_src == `SRC_SUB && sys_clk);
  COV_INST: cover property (instruction_clk);
  COV_KEEP: cover property (mw && wdata[1:0] == `SRC_NONE);
endmodule

bind system_clock_source_divider_select sel_chk #(.RING_DIV(RING_DIV)) sel_chk_inst (
  .clk(clk), .rst(rst), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sys_clk(sys_clk),
  .instruction_clk(instruction_clk), .machine_cycle(machine_cycle), .active_src(active_src));

// ### sim/system_clock_source_divider_select_tb.sv
// self-checking bench for the system clock selector
// assumes the design and checker compile first; pins toggle far below clk
`timescale 1ns/1ps
`include "clk_defs.svh"
module system_clock_source_divider_select_tb;
  localparam int RD = 2;
  logic              clk, rst, main_osc_in, sub_osc_in, wr, rd;
  logic              sys_clk, instruction_clk, machine_cycle;
  logic [2:0]        addr;
  logic [3:0]        wdata, rdata, m;
  clk_pkg::clk_src_t active_src;
  int                fails, cmp_count, mh, sh, mc, sc, o, j;

  system_clock_source_divider_select #(.RING_DIV(RD)) system_clock_source_divider_select_inst (
    .clk, .rst, .main_osc_in, .sub_osc_in, .addr, .wdata, .wr, .rd, .rdata, .sys_clk,
    .instruction_clk, .machine_cycle, .active_src);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pins are driven from clk so each period is exact and gaps can be compared strictly
  always @(posedge clk) begin
    mc <= (mc + 1) % mh;
    sc <= (sc + 1) % sh;
    if (mc == 0) main_osc_in <= !main_osc_in;
    if (sc == 0) sub_osc_in <= !sub_osc_in;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // expected system tick gap in clk cycles for a source code and a divide code
  function automatic int sys_gap_exp(int src, int dcode);
    int base;
    base = (src == 0) ? RD : (src == 1) ? 2 * mh : 2 * sh;
    return base << dcode;
  endfunction

  task automatic wreg(logic [2:0] a, logic [3:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [2:0] a, logic [3:0] e, logic [3:0] k = 4'hF);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata & k);
  endtask

  // the first gaps after a mode write may be stretched by the divider clear
  task automatic per(string nm, bit k, int e);
    int n;
    #1;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while ((k ? instruction_clk : sys_clk) !== 1'b1 && n < 3000);
    end
    chk(nm, e, n);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test;
  end

  initial begin
    {rst, wr, rd, addr, wdata, main_osc_in, sub_osc_in} = 12'h800;
    {fails, cmp_count, mc, sc, mh, sh} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h6, 32'hC};
    void'($urandom(64));
    mh = 5 + $urandom % 4;
    sh = 9 + $urandom % 6;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(`ADDR_MODE, `MODE_RESET);
    chk("active_src", `SRC_RING, active_src);
    per("sys_gap", 0, 8 * RD);
    per("inst_gap", 1, 24 * RD);
    $display("test reset done");
    o = $urandom % 12;
    for (int i = 0; i < 12; i++) begin
      j = (o + 5 * i) % 12;
      m = 4'((j / 3) * 4 + j % 3);
      wreg(`ADDR_MODE, m);
      rreg(`ADDR_MODE, m);
      chk("active_src", 16'(j % 3), active_src);
      per("sys_gap", 0, sys_gap_exp(j % 3, j / 3));
      per("inst_gap", 1, 3 * sys_gap_exp(j % 3, j / 3));
    end
    $display("test modes done");
    wreg(`ADDR_MODE, 4'hD);
    wreg(`ADDR_MODE, 4'h7);
    rreg(`ADDR_MODE, 4'h5);
    chk("active_src", `SRC_MAIN, active_src);
    per("sys_gap", 0, 4 * mh);
    $display("test code three done");
    wreg(3'h7, 4'($urandom));
    rreg(3'h7, 4'h0);
    rreg(`ADDR_MODE, 4'h5);
    $display("test unmapped done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(`ADDR_MODE, `MODE_RESET);
    chk("active_src", `SRC_RING, active_src);
    per("sys_gap", 0, 8 * RD);
    $display("test mid reset done");
    // clear lands just after an instruction tick, so the read falls mid-period
    wreg(`ADDR_MODE, 4'h0);
    per("inst_gap", 1, 3 * RD);
    wreg(`ADDR_MCYC0, 4'h0);
    repeat (60 * RD + 1) @(posedge clk);
    rreg(`ADDR_MCYC0, 4'h4);
    rreg(`ADDR_MCYC1, 4'h1);
    rreg(`ADDR_MCYC2, 4'h0);
    rreg(`ADDR_STATUS, 4'h3, 4'h3);
    $display("test machine cycles done");
    finish_test;
  end
endmodule
